//--- sde_consts.svh
`ifndef SDE_CONSTS_SVH
`define SDE_CONSTS_SVH

// Register indices; the byte address on the bus is four times the index.
`define SDE_IDX_SHAPE_CTRL   8'h90
`define SDE_IDX_LXS_LO       8'h91
`define SDE_IDX_LXS_HI       8'h92
`define SDE_IDX_LYS_LO       8'h93
`define SDE_IDX_LYS_HI       8'h94
`define SDE_IDX_LXE_LO       8'h95
`define SDE_IDX_LXE_HI       8'h96
`define SDE_IDX_LYE_LO       8'h97
`define SDE_IDX_LYE_HI       8'h98
`define SDE_IDX_CX_LO        8'h99
`define SDE_IDX_CX_HI        8'h9a
`define SDE_IDX_CY_LO        8'h9b
`define SDE_IDX_CY_HI        8'h9c
`define SDE_IDX_RADIUS       8'h9d
`define SDE_IDX_ELL_CTRL     8'ha0
`define SDE_IDX_LONG_LO      8'ha1
`define SDE_IDX_LONG_HI      8'ha2
`define SDE_IDX_SHORT_LO     8'ha3
`define SDE_IDX_SHORT_HI     8'ha4
`define SDE_IDX_EX_LO        8'ha5
`define SDE_IDX_EX_HI        8'ha6
`define SDE_IDX_EY_LO        8'ha7
`define SDE_IDX_EY_HI        8'ha8
`define SDE_IDX_TX_LO        8'ha9
`define SDE_IDX_TX_HI        8'haa
`define SDE_IDX_TY_LO        8'hab
`define SDE_IDX_TY_HI        8'hac

// Bit positions inside the two control registers.
`define SDE_BIT_LINE_GO      7
`define SDE_BIT_CIRC_GO      6
`define SDE_BIT_SHAPE_FILL   5
`define SDE_BIT_RECT_SEL     4
`define SDE_BIT_TRI_SEL      0
`define SDE_BIT_ELL_GO       7
`define SDE_BIT_ELL_FILL     6
`define SDE_BIT_RRECT_SEL    5
`define SDE_BIT_CURVE_SEL    4

// Reset and fill values.
`define SDE_RST_BYTE         8'h00
`define SDE_RST_X            10'h000
`define SDE_RST_Y            9'h000
`define SDE_RDATA_ZERO       32'h0000_0000

`endif

//--- sde_pkg.sv
package sde_pkg;

  // Kind of figure requested on the line, rectangle and triangle path.
  typedef enum logic [1:0] {SDE_LINE, SDE_RECT, SDE_TRI} sde_shape_t;

  // Kind of figure requested on the ellipse path.
  typedef enum logic [1:0] {SDE_ELLIPSE, SDE_CURVE, SDE_RRECT} sde_ell_mode_t;

  typedef struct packed {
    logic [9:0] x;
    logic [8:0] y;
  } sde_point_t;

  typedef struct packed {
    sde_shape_t shape;
    logic       fill;
    sde_point_t start;
    sde_point_t stop;
    sde_point_t third;
  } sde_line_par_t;

  typedef struct packed {
    logic       fill;
    sde_point_t center;
    logic [7:0] radius;
  } sde_circ_par_t;

  typedef struct packed {
    sde_ell_mode_t mode;
    logic          fill;
    logic [1:0]    curve_part_select;
    sde_point_t    center;
    logic [9:0]    long_axis;
    logic [8:0]    short_axis;
  } sde_ell_par_t;

endpackage

//--- sde_shape_ctrl.sv
// How it works
// (R1) Shape bit7: write starts/stops, read shows busy.
// (R2) Shape bit6: circle start/stop, read shows busy.
// (R3) Shape bit5: outline or filled interior.
// (R4) Shape bit4: line or rectangle.
// (R5) Shape bit0: line/rectangle path or triangle.
// (R6) Line start x: low byte plus two bits.
// (R7) Line start y: low byte plus one bit.
// (R8) Line end x: low byte plus two bits.
// (R9) Line end y: low byte plus one bit.
// (R10) Circle centre x: low byte plus two bits.
// (R11) Circle centre y: low byte plus one bit.
// (R12) Circle radius is a full eight-bit byte.
// (R13) Ellipse bit7: start/stop, read shows busy.
// (R14) Ellipse bit6: outline or filled interior.
// (R15) Ellipse bit5: ellipse family or rounded rectangle.
// (R16) Ellipse bit4: full ellipse or curve segment.
// (R17) Ellipse bits1-0 pick the curve part.
// (R18) Long axis low byte has its own register.
// (R19) Long axis bits 9-8 in next register.
// (R20) Short axis: low byte plus one bit.
// (R21) Ellipse centre: 10-bit x, 9-bit y, split.
// (R22) Triangle third vertex: 10-bit x, 9-bit y.
// (R23) Software keeps parameters steady while busy.
`include "sde_consts.svh"

module sde_shape_ctrl (
  // Clock and reset.
  input  wire logic                clk_sys_i,
  input  wire logic                reset_n_i,
  // APB slave.
  input  wire logic                psel_i,
  input  wire logic                penable_i,
  input  wire logic                pwrite_i,
  input  wire logic [11:0]         paddr_i,
  input  wire logic [31:0]         pwdata_i,
  input  wire logic [3:0]          pstrb_i,
  output logic      [31:0]         prdata_o,
  output logic                     pready_o,
  output logic                     pslverr_o,
  // Rasteriser handshakes.
  output logic                     line_go_o,
  output logic                     line_stop_o,
  input  wire logic                line_done_i,
  output logic                     circle_go_o,
  output logic                     circle_stop_o,
  input  wire logic                circle_done_i,
  output logic                     ellipse_go_o,
  output logic                     ellipse_stop_o,
  input  wire logic                ellipse_done_i,
  // Figure parameters.
  output sde_pkg::sde_line_par_t   line_par_o,
  output sde_pkg::sde_circ_par_t   circle_par_o,
  output sde_pkg::sde_ell_par_t    ellipse_par_o
);

  logic [7:0]  idx;
  logic        mapped;
  logic        access;
  logic        wr;
  logic [7:0]  wb;
  logic [7:0]  rd_byte;
  logic        rd_hit;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  logic [9:0]  lxs_reg, lxe_reg, cx_reg, ex_reg, tx_reg, long_reg;
  logic [8:0]  lys_reg, lye_reg, cy_reg, ey_reg, ty_reg, short_reg;
  logic [7:0]  radius_reg;
  logic        s_fill_reg, s_rect_reg, s_tri_reg;
  logic        e_fill_reg, e_rrect_reg, e_curve_reg;
  logic [1:0]  e_part_reg;
  logic        line_busy_reg, circ_busy_reg, ell_busy_reg;
  logic        line_busy_next, circ_busy_next, ell_busy_next;
  logic        wr_shape, wr_ell;

  // Replace the low byte of a 10-bit field.
  function automatic logic [9:0] lo10(input logic [9:0] old, input logic [7:0] d);
    lo10 = {old[9:8], d};
  endfunction

  // Replace bits 9-8 of a 10-bit field from data bits 1-0.
  function automatic logic [9:0] hi10(input logic [9:0] old, input logic [7:0] d);
    hi10 = {d[1:0], old[7:0]};
  endfunction

  // Replace the low byte of a 9-bit field.
  function automatic logic [8:0] lo9(input logic [8:0] old, input logic [7:0] d);
    lo9 = {old[8], d};
  endfunction

  // Replace bit 8 of a 9-bit field from data bit 0.
  function automatic logic [8:0] hi9(input logic [8:0] old, input logic [7:0] d);
    hi9 = {d[0], old[7:0]};
  endfunction

  // Upper bits of a 10-bit field as a read byte; unused bits read zero.
  function automatic logic [7:0] rd_hi10(input logic [9:0] v);
    rd_hi10 = {6'h00, v[9:8]};
  endfunction

  // Upper bit of a 9-bit field as a read byte; unused bits read zero.
  function automatic logic [7:0] rd_hi9(input logic [8:0] v);
    rd_hi9 = {7'h00, v[8]};
  endfunction

  // Decode; every transfer finishes in its first access cycle, so pready is constant.
  assign idx      = paddr_i[9:2];
  assign access   = psel_i & penable_i & pready_o;
  assign wb       = pwdata_i[7:0];
  assign mapped   = rd_hit & (paddr_i[11:10] == 2'h0) & (paddr_i[1:0] == 2'h0);
  assign wr       = access & pwrite_i & mapped & pstrb_i[0];
  assign wr_shape = wr & (idx == `SDE_IDX_SHAPE_CTRL);
  assign wr_ell   = wr & (idx == `SDE_IDX_ELL_CTRL);
  assign pready_o = 1'b1;

  // Read multiplexer; reserved bits read as zero and busy bits show engine state.
  always_comb begin
    rd_hit  = 1'b1;
    rd_byte = `SDE_RST_BYTE;
    case (idx)
      `SDE_IDX_SHAPE_CTRL: rd_byte = {line_busy_reg, circ_busy_reg, s_fill_reg, s_rect_reg,
                                      3'h0, s_tri_reg}; // R1 R2
      `SDE_IDX_LXS_LO:     rd_byte = lxs_reg[7:0];
      `SDE_IDX_LXS_HI:     rd_byte = rd_hi10(lxs_reg);
      `SDE_IDX_LYS_LO:     rd_byte = lys_reg[7:0];
      `SDE_IDX_LYS_HI:     rd_byte = rd_hi9(lys_reg);
      `SDE_IDX_LXE_LO:     rd_byte = lxe_reg[7:0];
      `SDE_IDX_LXE_HI:     rd_byte = rd_hi10(lxe_reg);
      `SDE_IDX_LYE_LO:     rd_byte = lye_reg[7:0];
      `SDE_IDX_LYE_HI:     rd_byte = rd_hi9(lye_reg);
      `SDE_IDX_CX_LO:      rd_byte = cx_reg[7:0];
      `SDE_IDX_CX_HI:      rd_byte = rd_hi10(cx_reg);
      `SDE_IDX_CY_LO:      rd_byte = cy_reg[7:0];
      `SDE_IDX_CY_HI:      rd_byte = rd_hi9(cy_reg);
      `SDE_IDX_RADIUS:     rd_byte = radius_reg;
      `SDE_IDX_ELL_CTRL:   rd_byte = {ell_busy_reg, e_fill_reg, e_rrect_reg, e_curve_reg,
                                      2'h0, e_part_reg}; // R13
      `SDE_IDX_LONG_LO:    rd_byte = long_reg[7:0];
      `SDE_IDX_LONG_HI:    rd_byte = rd_hi10(long_reg);
      `SDE_IDX_SHORT_LO:   rd_byte = short_reg[7:0];
      `SDE_IDX_SHORT_HI:   rd_byte = rd_hi9(short_reg);
      `SDE_IDX_EX_LO:      rd_byte = ex_reg[7:0];
      `SDE_IDX_EX_HI:      rd_byte = rd_hi10(ex_reg);
      `SDE_IDX_EY_LO:      rd_byte = ey_reg[7:0];
      `SDE_IDX_EY_HI:      rd_byte = rd_hi9(ey_reg);
      `SDE_IDX_TX_LO:      rd_byte = tx_reg[7:0];
      `SDE_IDX_TX_HI:      rd_byte = rd_hi10(tx_reg);
      `SDE_IDX_TY_LO:      rd_byte = ty_reg[7:0];
      `SDE_IDX_TY_HI:      rd_byte = rd_hi9(ty_reg);
      default:             rd_hit  = 1'b0;
    endcase
  end

  // Read data and error are captured in the setup cycle so both come from flip-flops.
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      prdata_reg  <= `SDE_RDATA_ZERO;
      pslverr_reg <= 1'b0;
    end else if (psel_i & ~penable_i) begin
      prdata_reg  <= (mapped & ~pwrite_i) ? {24'h000000, rd_byte} : `SDE_RDATA_ZERO;
      pslverr_reg <= ~mapped;
    end
  end

  assign prdata_o  = prdata_reg;
  assign pslverr_o = pslverr_reg & psel_i & penable_i;

  // Coordinate and size registers; upper-byte writes touch only the upper bits.
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      lxs_reg <= `SDE_RST_X;
      lys_reg <= `SDE_RST_Y;
      lxe_reg <= `SDE_RST_X;
      lye_reg <= `SDE_RST_Y;
      cx_reg  <= `SDE_RST_X;
      cy_reg  <= `SDE_RST_Y;
      radius_reg <= `SDE_RST_BYTE;
      long_reg  <= `SDE_RST_X;
      short_reg <= `SDE_RST_Y;
      ex_reg  <= `SDE_RST_X;
      ey_reg  <= `SDE_RST_Y;
      tx_reg  <= `SDE_RST_X;
      ty_reg  <= `SDE_RST_Y;
    end else if (wr) begin
      case (idx)
        `SDE_IDX_LXS_LO:   lxs_reg <= lo10(lxs_reg, wb); // R6
        `SDE_IDX_LXS_HI:   lxs_reg <= hi10(lxs_reg, wb); // R6
        `SDE_IDX_LYS_LO:   lys_reg <= lo9(lys_reg, wb); // R7
        `SDE_IDX_LYS_HI:   lys_reg <= hi9(lys_reg, wb); // R7
        `SDE_IDX_LXE_LO:   lxe_reg <= lo10(lxe_reg, wb); // R8
        `SDE_IDX_LXE_HI:   lxe_reg <= hi10(lxe_reg, wb); // R8
        `SDE_IDX_LYE_LO:   lye_reg <= lo9(lye_reg, wb); // R9
        `SDE_IDX_LYE_HI:   lye_reg <= hi9(lye_reg, wb); // R9
        `SDE_IDX_CX_LO:    cx_reg <= lo10(cx_reg, wb); // R10
        `SDE_IDX_CX_HI:    cx_reg <= hi10(cx_reg, wb); // R10
        `SDE_IDX_CY_LO:    cy_reg <= lo9(cy_reg, wb); // R11
        `SDE_IDX_CY_HI:    cy_reg <= hi9(cy_reg, wb); // R11
        `SDE_IDX_RADIUS:   radius_reg <= wb; // R12
        `SDE_IDX_LONG_LO:  long_reg <= lo10(long_reg, wb); // R18
        `SDE_IDX_LONG_HI:  long_reg <= hi10(long_reg, wb); // R19
        `SDE_IDX_SHORT_LO: short_reg <= lo9(short_reg, wb); // R20
        `SDE_IDX_SHORT_HI: short_reg <= hi9(short_reg, wb); // R20
        `SDE_IDX_EX_LO:    ex_reg <= lo10(ex_reg, wb); // R21
        `SDE_IDX_EX_HI:    ex_reg <= hi10(ex_reg, wb); // R21
        `SDE_IDX_EY_LO:    ey_reg <= lo9(ey_reg, wb); // R21
        `SDE_IDX_EY_HI:    ey_reg <= hi9(ey_reg, wb); // R21
        `SDE_IDX_TX_LO:    tx_reg <= lo10(tx_reg, wb); // R22
        `SDE_IDX_TX_HI:    tx_reg <= hi10(tx_reg, wb); // R22
        `SDE_IDX_TY_LO:    ty_reg <= lo9(ty_reg, wb); // R22
        `SDE_IDX_TY_HI:    ty_reg <= hi9(ty_reg, wb); // R22
        default: ;
      endcase
    end
  end

  // Mode and fill bits of both control registers.
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      s_fill_reg  <= 1'b0;
      s_rect_reg  <= 1'b0;
      s_tri_reg   <= 1'b0;
      e_fill_reg  <= 1'b0;
      e_rrect_reg <= 1'b0;
      e_curve_reg <= 1'b0;
      e_part_reg  <= 2'h0;
    end else begin
      if (wr_shape) begin
        s_fill_reg <= wb[`SDE_BIT_SHAPE_FILL]; // R3
        s_rect_reg <= wb[`SDE_BIT_RECT_SEL]; // R4
        s_tri_reg  <= wb[`SDE_BIT_TRI_SEL]; // R5
      end
      if (wr_ell) begin
        e_fill_reg  <= wb[`SDE_BIT_ELL_FILL]; // R14
        e_rrect_reg <= wb[`SDE_BIT_RRECT_SEL]; // R15
        e_curve_reg <= wb[`SDE_BIT_CURVE_SEL]; // R16
        e_part_reg  <= wb[1:0]; // R17
      end
    end
  end

  // Busy flags: a start written in the same cycle as a done pulse wins, so it is not lost.
  always_comb begin
    line_busy_next = line_busy_reg;
    if (line_done_i | (wr_shape & ~wb[`SDE_BIT_LINE_GO])) line_busy_next = 1'b0;
    if (wr_shape & wb[`SDE_BIT_LINE_GO]) line_busy_next = 1'b1; // R1
    circ_busy_next = circ_busy_reg;
    if (circle_done_i | (wr_shape & ~wb[`SDE_BIT_CIRC_GO])) circ_busy_next = 1'b0;
    if (wr_shape & wb[`SDE_BIT_CIRC_GO]) circ_busy_next = 1'b1; // R2
    ell_busy_next = ell_busy_reg;
    if (ellipse_done_i | (wr_ell & ~wb[`SDE_BIT_ELL_GO])) ell_busy_next = 1'b0;
    if (wr_ell & wb[`SDE_BIT_ELL_GO]) ell_busy_next = 1'b1; // R13
  end

  // Busy registers and the go and stop pulses; a stop only goes out if something runs.
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      line_busy_reg  <= 1'b0;
      circ_busy_reg  <= 1'b0;
      ell_busy_reg   <= 1'b0;
      line_go_o      <= 1'b0;
      circle_go_o    <= 1'b0;
      ellipse_go_o   <= 1'b0;
      line_stop_o    <= 1'b0;
      circle_stop_o  <= 1'b0;
      ellipse_stop_o <= 1'b0;
    end else begin
      line_busy_reg  <= line_busy_next;
      circ_busy_reg  <= circ_busy_next;
      ell_busy_reg   <= ell_busy_next;
      line_go_o      <= wr_shape & wb[`SDE_BIT_LINE_GO]; // R1
      circle_go_o    <= wr_shape & wb[`SDE_BIT_CIRC_GO]; // R2
      ellipse_go_o   <= wr_ell & wb[`SDE_BIT_ELL_GO]; // R13
      line_stop_o    <= wr_shape & ~wb[`SDE_BIT_LINE_GO] & line_busy_reg; // R1
      circle_stop_o  <= wr_shape & ~wb[`SDE_BIT_CIRC_GO] & circ_busy_reg; // R2
      ellipse_stop_o <= wr_ell & ~wb[`SDE_BIT_ELL_GO] & ell_busy_reg; // R13
    end
  end

  // Parameters go straight from the registers; software must not alter them mid-figure.
  always_comb begin
    line_par_o.shape = s_tri_reg ? sde_pkg::SDE_TRI :
                       (s_rect_reg ? sde_pkg::SDE_RECT : sde_pkg::SDE_LINE); // R4 R5
    line_par_o.fill  = s_fill_reg; // R3
    line_par_o.start = '{x: lxs_reg, y: lys_reg}; // R23
    line_par_o.stop  = '{x: lxe_reg, y: lye_reg};
    line_par_o.third = '{x: tx_reg, y: ty_reg}; // R22
    circle_par_o.fill   = s_fill_reg; // R3
    circle_par_o.center = '{x: cx_reg, y: cy_reg};
    circle_par_o.radius = radius_reg; // R12
    ellipse_par_o.mode  = e_rrect_reg ? sde_pkg::SDE_RRECT :
                          (e_curve_reg ? sde_pkg::SDE_CURVE : sde_pkg::SDE_ELLIPSE); // R15 R16
    ellipse_par_o.fill  = e_fill_reg; // R14
    ellipse_par_o.curve_part_select = e_part_reg; // R17
    ellipse_par_o.center     = '{x: ex_reg, y: ey_reg}; // R21
    ellipse_par_o.long_axis  = long_reg;
    ellipse_par_o.short_axis = short_reg;
  end

  property p_line_start;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (wr_shape & wb[`SDE_BIT_LINE_GO]) |=> (line_go_o & line_busy_reg);
  endproperty
  a_line_start: assert property (p_line_start) else $error("line start not taken"); // R1

  property p_line_done;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (line_busy_reg & line_done_i & ~wr_shape) |=> ~line_busy_reg;
  endproperty
  a_line_done: assert property (p_line_done) else $error("line busy after done"); // R1

  property p_circ_stop;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (circ_busy_reg & wr_shape & ~wb[`SDE_BIT_CIRC_GO]) |=> (circle_stop_o & ~circ_busy_reg);
  endproperty
  a_circ_stop: assert property (p_circ_stop) else $error("circle stop missing"); // R2

  property p_ctrl_read;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (psel_i & ~penable_i & ~pwrite_i & mapped & (idx == `SDE_IDX_SHAPE_CTRL))
      |=> (prdata_o[`SDE_BIT_LINE_GO] == $past(line_busy_reg)) && (prdata_o[3:1] == 3'h0);
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("shape status read wrong"); // R1

  property p_fill;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      wr_shape |=> (circle_par_o.fill == $past(wb[`SDE_BIT_SHAPE_FILL]));
  endproperty
  a_fill: assert property (p_fill) else $error("fill select lost"); // R3

  property p_tri;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (wr_shape & wb[`SDE_BIT_TRI_SEL]) |=> (line_par_o.shape == sde_pkg::SDE_TRI);
  endproperty
  a_tri: assert property (p_tri) else $error("triangle not selected"); // R5

  property p_xhi;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (wr & (idx == `SDE_IDX_LXS_HI))
      |=> (lxs_reg == {$past(wb[1:0]), $past(lxs_reg[7:0])});
  endproperty
  a_xhi: assert property (p_xhi) else $error("start x upper bits wrong"); // R6

  property p_radius;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (wr & (idx == `SDE_IDX_RADIUS)) |=> (circle_par_o.radius == $past(wb));
  endproperty
  a_radius: assert property (p_radius) else $error("radius not stored"); // R12

  property p_ell_set_wins;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (wr_ell & wb[`SDE_BIT_ELL_GO] & ellipse_done_i) |=> ell_busy_reg ##1 1'b1;
  endproperty
  a_ell_set_wins: assert property (p_ell_set_wins) else $error("ellipse start lost"); // R13

  property p_rrect;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (wr_ell & wb[`SDE_BIT_RRECT_SEL]) |=> (ellipse_par_o.mode == sde_pkg::SDE_RRECT);
  endproperty
  a_rrect: assert property (p_rrect) else $error("rounded rectangle not selected"); // R15

  property p_unmapped;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (psel_i & ~penable_i & ~mapped) ##1 (psel_i & penable_i) |-> pslverr_o;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged"); // R1

endmodule

//--- tb_sde_shape_ctrl.sv
`include "sde_consts.svh"

module tb_sde_shape_ctrl;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] idx_shape = `SDE_IDX_SHAPE_CTRL;
  localparam logic [7:0] idx_ell   = `SDE_IDX_ELL_CTRL;

  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] wd;
    logic [7:0] ex;
  } sde_row_t;

  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] wd;
    logic [7:0] ex;
    logic [1:0] mode;
    logic       fill;
    logic [1:0] part;
  } sde_mode_t;

  logic                   clk_sys_i;
  logic                   reset_n_i;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic [11:0]            paddr;
  logic [31:0]            pwdata;
  logic [3:0]             pstrb;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic [2:0]             go;
  logic [2:0]             stp;
  logic [2:0]             done;
  sde_pkg::sde_line_par_t line_par;
  sde_pkg::sde_circ_par_t circ_par;
  sde_pkg::sde_ell_par_t  ell_par;
  int                     bad_count;
  int                     check_count;
  int                     cycles;
  int                     pc [6];
  int                     xp [6];
  logic [31:0]            rd;
  logic                   er;

  // Parameter registers: written value beside the value that must read back.
  sde_row_t prm [25] = '{
    '{8'h91, 8'h91, 8'h91}, '{8'h92, 8'hfe, 8'h02}, '{8'h93, 8'h93, 8'h93},
    '{8'h94, 8'hff, 8'h01}, '{8'h95, 8'h95, 8'h95}, '{8'h96, 8'hfd, 8'h01},
    '{8'h97, 8'h97, 8'h97}, '{8'h98, 8'hff, 8'h01}, '{8'h99, 8'h99, 8'h99},
    '{8'h9a, 8'hff, 8'h03}, '{8'h9b, 8'h9b, 8'h9b}, '{8'h9c, 8'hff, 8'h01},
    '{8'h9d, 8'h9d, 8'h9d}, '{8'ha1, 8'ha1, 8'ha1}, '{8'ha2, 8'hfe, 8'h02},
    '{8'ha3, 8'ha3, 8'ha3}, '{8'ha4, 8'hff, 8'h01}, '{8'ha5, 8'ha5, 8'ha5},
    '{8'ha6, 8'hfd, 8'h01}, '{8'ha7, 8'ha7, 8'ha7}, '{8'ha8, 8'hff, 8'h01},
    '{8'ha9, 8'ha9, 8'ha9}, '{8'haa, 8'hff, 8'h03}, '{8'hab, 8'hab, 8'hab},
    '{8'hac, 8'hff, 8'h01}};

  // Mode rows: control write, read-back and the figure selection it must give.
  sde_mode_t mrow [7] = '{
    '{idx_shape, 8'h3f, 8'h31, 2'd2, 1'b1, 2'd0}, '{idx_shape, 8'h10, 8'h10, 2'd1, 1'b0, 2'd0},
    '{idx_shape, 8'h20, 8'h20, 2'd0, 1'b1, 2'd0}, '{idx_ell, 8'h5f, 8'h53, 2'd1, 1'b1, 2'd3},
    '{idx_ell, 8'h21, 8'h21, 2'd2, 1'b0, 2'd1}, '{idx_ell, 8'h3e, 8'h32, 2'd2, 1'b0, 2'd2},
    '{idx_ell, 8'h40, 8'h40, 2'd0, 1'b1, 2'd0}};

  // Drawing paths: line, circle, ellipse; control register and go value.
  logic [7:0] go_idx [3] = '{idx_shape, idx_shape, idx_ell};
  logic [7:0] go_wd [3]  = '{8'h80, 8'h40, 8'h80};

  sde_shape_ctrl dut (
    .clk_sys_i      (clk_sys_i),
    .reset_n_i      (reset_n_i),
    .psel_i         (psel),
    .penable_i      (penable),
    .pwrite_i       (pwrite),
    .paddr_i        (paddr),
    .pwdata_i       (pwdata),
    .pstrb_i        (pstrb),
    .prdata_o       (prdata),
    .pready_o       (pready),
    .pslverr_o      (pslverr),
    .line_go_o      (go[0]),
    .line_stop_o    (stp[0]),
    .line_done_i    (done[0]),
    .circle_go_o    (go[1]),
    .circle_stop_o  (stp[1]),
    .circle_done_i  (done[1]),
    .ellipse_go_o   (go[2]),
    .ellipse_stop_o (stp[2]),
    .ellipse_done_i (done[2]),
    .line_par_o     (line_par),
    .circle_par_o   (circ_par),
    .ellipse_par_o  (ell_par)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  // Pulses are counted at the falling edge so that the count is settled when read.
  always @(negedge clk_sys_i) begin
    for (int i = 0; i < 3; i++) begin
      if (go[i] === 1'b1) pc[i]++;
      if (stp[i] === 1'b1) pc[i + 3]++;
    end
  end

  // A hung handshake would otherwise stall the run for ever.
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 5000) begin
      $display("MISMATCH timeout expected end of tests seen %0d cycles", cycles);
      bad_count++;
      end_sim();
    end
  end

  task end_sim();
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask

  // One transfer with an idle cycle before it, so no signal is driven twice in a step.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
           output logic [31:0] r, output logic e);
    @(posedge clk_sys_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    @(posedge clk_sys_i);
    while (pready !== 1'b1) @(posedge clk_sys_i);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] i, input logic [7:0] d);
    apb(1'b1, {2'b00, i, 2'b00}, {24'h00_0000, d}, 4'hf, rd, er);
    chk("wr_slverr", 32'h0000_0000, {31'h0, er});
  endtask

  task rdc(input string n, input logic [7:0] i, input logic [7:0] x);
    apb(1'b0, {2'b00, i, 2'b00}, 32'h0000_0000, 4'h0, rd, er);
    chk(n, {24'h00_0000, x}, rd);
    chk("rd_slverr", 32'h0000_0000, {31'h0, er});
  endtask

  task bad(input logic w, input logic [11:0] a);
    apb(w, a, 32'h0000_00aa, 4'hf, rd, er);
    chk("bad_slverr", 32'h0000_0001, {31'h0, er});
    if (!w) chk("bad_rdata", 32'h0000_0000, rd);
  endtask

  task pdone(input int i);
    @(posedge clk_sys_i);
    done[i] <= 1'b1;
    @(posedge clk_sys_i);
    done[i] <= 1'b0;
  endtask

  task chk_pulses();
    for (int k = 0; k < 6; k++) chk("pulse_count", xp[k], pc[k]);
  endtask

  initial begin
    reset_n_i = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 12'h000;
    pwdata    = 32'h0000_0000;
    pstrb     = 4'h0;
    done      = 3'h0;
    repeat (12) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    // Reset values, then every parameter register written and read back.
    rdc("rst_shape", idx_shape, 8'h00);
    rdc("rst_ell", idx_ell, 8'h00);
    foreach (prm[k]) rdc("rst_param", prm[k].idx, 8'h00);
    foreach (prm[k]) wr(prm[k].idx, prm[k].wd);
    foreach (prm[k]) rdc("param_rd", prm[k].idx, prm[k].ex);
    chk("line_start", {13'h0, 10'h291, 9'h193}, {13'h0, line_par.start});
    chk("line_stop", {13'h0, 10'h195, 9'h197}, {13'h0, line_par.stop});
    chk("tri_vertex", {13'h0, 10'h3a9, 9'h1ab}, {13'h0, line_par.third});
    chk("circ_center", {13'h0, 10'h399, 9'h19b}, {13'h0, circ_par.center});
    chk("circ_radius", 32'h0000_009d, {24'h0, circ_par.radius});
    chk("ell_center", {13'h0, 10'h1a5, 9'h1a7}, {13'h0, ell_par.center});
    chk("long_axis", 32'h0000_02a1, {22'h0, ell_par.long_axis});
    chk("short_axis", 32'h0000_01a3, {23'h0, ell_par.short_axis});
    $display("Test parameters done");
    // Each path: start, done, done while idle, restart while busy, stop.
    for (int i = 0; i < 3; i++) begin
      wr(go_idx[i], go_wd[i]);
      xp[i]++;
      rdc("busy", go_idx[i], go_wd[i]);
      pdone(i);
      rdc("idle", go_idx[i], 8'h00);
      pdone(i);
      wr(go_idx[i], go_wd[i]);
      wr(go_idx[i], go_wd[i]);
      xp[i] += 2;
      wr(go_idx[i], 8'h00);
      xp[i + 3]++;
      rdc("stopped", go_idx[i], 8'h00);
      chk_pulses();
    end
    // Line and circle run side by side; only the busy one sees a stop.
    wr(idx_shape, 8'hc0);
    xp[0]++;
    xp[1]++;
    rdc("both_busy", idx_shape, 8'hc0);
    pdone(0);
    rdc("circ_only", idx_shape, 8'h40);
    wr(idx_shape, 8'h00);
    xp[4]++;
    rdc("both_idle", idx_shape, 8'h00);
    // A start that meets a done pulse at the same edge must not be lost.
    done[2] <= 1'b1;
    wr(idx_ell, 8'h80);
    done[2] <= 1'b0;
    xp[2]++;
    rdc("set_wins", idx_ell, 8'h80);
    wr(idx_ell, 8'h00);
    xp[5]++;
    rdc("set_wins_stop", idx_ell, 8'h00);
    chk_pulses();
    $display("Test drawing handshakes done");
    // Figure selection, fill and curve part through both control registers.
    foreach (mrow[k]) begin
      wr(mrow[k].idx, mrow[k].wd);
      rdc("mode_rd", mrow[k].idx, mrow[k].ex);
      if (mrow[k].idx == idx_shape) begin
        chk("line_shape", {30'h0, mrow[k].mode}, {30'h0, line_par.shape});
        chk("line_fill", {31'h0, mrow[k].fill}, {31'h0, line_par.fill});
        chk("circ_fill", {31'h0, mrow[k].fill}, {31'h0, circ_par.fill});
      end else begin
        chk("ell_mode", {30'h0, mrow[k].mode}, {30'h0, ell_par.mode});
        chk("ell_fill", {31'h0, mrow[k].fill}, {31'h0, ell_par.fill});
        chk("ell_part", {30'h0, mrow[k].part}, {30'h0, ell_par.curve_part_select});
      end
    end
    $display("Test modes done");
    // Unmapped, misaligned and aliased places must not reach the low byte of x start.
    bad(1'b0, 12'h278);
    bad(1'b0, 12'h27c);
    bad(1'b0, 12'h23c);
    bad(1'b1, 12'h2b4);
    bad(1'b1, 12'h245);
    bad(1'b1, 12'h644);
    apb(1'b1, 12'h244, 32'h0000_0055, 4'h0, rd, er);
    chk("strb_slverr", 32'h0000_0000, {31'h0, er});
    rdc("x_start_kept", 8'h91, 8'h91);
    $display("Test refused accesses done");
    // A reset in mid-draw clears busy and parameters.
    wr(idx_shape, 8'h80);
    xp[0]++;
    @(posedge clk_sys_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    rdc("rst2_shape", idx_shape, 8'h00);
    rdc("rst2_param", 8'h91, 8'h00);
    chk("rst2_radius", 32'h0000_0000, {24'h0, circ_par.radius});
    chk_pulses();
    $display("Test mid-run reset done");
    end_sim();
  end
endmodule
